/* pkg/sffc_pkg.sv */
// Constants and types of the servo feedforward compensation stage
package sffc_pkg;
   // ---------------------------------------------------------------
   // Bus and data widths
   // ---------------------------------------------------------------
   localparam int AW = 8;
   localparam int DW = 32;
   localparam int RW = 24;  // Width of speed and force references
   // ---------------------------------------------------------------
   // Register byte offsets
   // ---------------------------------------------------------------
   localparam logic [AW-1:0] A_CTRL      = 8'h00;
   localparam logic [AW-1:0] A_FF_GAIN   = 8'h04;
   localparam logic [AW-1:0] A_FF_FILT   = 8'h08;
   localparam logic [AW-1:0] A_FRC_GAIN  = 8'h0c;
   localparam logic [AW-1:0] A_EXT_FILT  = 8'h10;
   localparam logic [AW-1:0] A_SPD_GAIN  = 8'h14;
   localparam logic [AW-1:0] A_SRC_SEL   = 8'h18;
   localparam logic [AW-1:0] A_STATUS    = 8'h1c;
   localparam logic [AW-1:0] A_SPD_FF    = 8'h20;
   localparam logic [AW-1:0] A_FRC_FF    = 8'h24;
   // ---------------------------------------------------------------
   // Control and source select register fields
   // ---------------------------------------------------------------
   localparam int C_MODE_LO  = 0;
   localparam int C_MODE_HI  = 1;
   localparam int C_PCTRL    = 2;
   localparam int C_POS_INT  = 3;
   localparam int C_MFC_EN   = 4;
   localparam int C_MF_COMB  = 5;
   localparam int C_FLIM_ANA = 6;
   localparam int C_RESTART  = 7;
   localparam int S_FRC_LO   = 0;
   localparam int S_FRC_HI   = 3;
   localparam int S_SPD_LO   = 4;
   localparam int S_SPD_HI   = 7;
   // ---------------------------------------------------------------
   // Setting ranges and reset values
   // ---------------------------------------------------------------
   localparam logic [15:0] FF_GAIN_MAX  = 16'h0064; // 100 %
   localparam logic [15:0] FF_GAIN_DEF  = 16'h0000;
   localparam logic [15:0] FF_FILT_MAX  = 16'h1900; // 6400
   localparam logic [15:0] FILT_DEF     = 16'h0000;
   localparam logic [15:0] FRC_GAIN_MIN = 16'h000a; // 10
   localparam logic [15:0] FRC_GAIN_MAX = 16'h0064; // 100
   localparam logic [15:0] FRC_GAIN_DEF = 16'h001e; // 30
   localparam logic [15:0] SPD_GAIN_MIN = 16'h0096; // 150
   localparam logic [15:0] SPD_GAIN_MAX = 16'h0bb8; // 3000
   localparam logic [15:0] SPD_GAIN_DEF = 16'h0258; // 600
   localparam logic [3:0]  FRC_SRC_ON   = 4'h2;
   localparam logic [3:0]  SPD_SRC_ON   = 4'h1;
   localparam logic [3:0]  SRC_OFF      = 4'h0;
   // ---------------------------------------------------------------
   // Scaling: ADC in mV, rated value is 4096 counts
   // ---------------------------------------------------------------
   localparam logic signed [31:0] RATED     = 32'sh0000_1000;
   localparam logic signed [31:0] PCT_FULL  = 32'sh0000_0064;
   localparam logic signed [31:0] MV_CENTI  = 32'sh0000_000a;
   localparam logic signed [31:0] MV_DECI   = 32'sh0000_0064;
   // ---------------------------------------------------------------
   // Timing: loop update every 0.01 ms, one filter time unit
   // ---------------------------------------------------------------
   localparam int CLK_PS     = 5000;
   localparam int TICK_PS    = 10000000;
   localparam int TICK_CYC   = TICK_PS / CLK_PS;
   localparam int TCW        = 12;
   // ---------------------------------------------------------------
   // Types
   // ---------------------------------------------------------------
   typedef enum logic [1:0] {
      SFFC_MODE_SPEED = 2'b00,
      SFFC_MODE_POS   = 2'b01,
      SFFC_MODE_FORCE = 2'b10,
      SFFC_MODE_OTHER = 2'b11
   } sffc_mode_t;
   typedef struct packed {
      logic [15:0] ff_gain;
      logic [15:0] ff_filt;
      logic [15:0] frc_gain;
      logic [15:0] ext_filt;
      logic [15:0] spd_gain;
      logic        mf_comb;
   } sffc_cfg_t;
endpackage : sffc_pkg

/* design/sffc_top.sv */
// Feedforward compensation stage of the servo control loop
//
// Operation
// - Position mode adds scaled internal feedforward
// - Internal feedforward lag filter, immediate setting
// - Force feedforward only in speed, position
// - Force input used when source is 2
// - Force input gain 10 to 100
// - Force feedforward excludes analog force limit
// - Model following combination select, immediate
// - Speed feedforward only in position mode
// - Speed input used when source is 1
// - Speed input gain 150 to 3000
// - Proportional-only select in speed, position
// - Position integral only in position mode
// - Sum feedforward into speed, force references
//
// Decided for this implementation: the register offsets and strobed register access.
`timescale 1ns/100ps
module sffc_top
   import sffc_pkg::*;
(
   input  wire logic                 core_clk,
   input  wire logic                 sys_rst,
   input  wire logic [AW-1:0]        reg_addr,
   input  wire logic [DW-1:0]        reg_wdata,
   input  wire logic                 reg_wr,
   input  wire logic                 reg_rd,
   output logic      [DW-1:0]        reg_rdata,
   input  wire logic                 ref_pulse_in,
   input  wire logic                 ref_sign_in,
   input  wire logic signed [15:0]   speed_adc_mv,
   input  wire logic signed [15:0]   force_adc_mv,
   input  wire logic signed [RW-1:0] speed_ref_in,
   input  wire logic signed [RW-1:0] force_ref_in,
   output logic signed [RW-1:0]      speed_ref_out,
   output logic signed [RW-1:0]      force_ref_out,
   output logic                      loop_tick,
   output logic                      p_control_on,
   output logic                      pos_integral_on,
   output logic                      force_limit_on
);
   // ---------------------------------------------------------------
   // Helper functions
   // ---------------------------------------------------------------
   // First-order lag, one step of 0.01 ms; t is in 0.01 ms units
   function automatic logic signed [31:0] sffc_lag(
      input logic signed [31:0] y,
      input logic signed [31:0] x,
      input logic [15:0]        t);
      logic signed [31:0] den;
      den = $signed({16'h0000, t}) + 32'sh1;
      sffc_lag = y + (x - y) / den;
   endfunction : sffc_lag

   // Clip to the reference width instead of wrapping
   function automatic logic signed [RW-1:0] sffc_sat(
      input logic signed [31:0] v);
      logic signed [31:0] hi;
      logic signed [31:0] lo;
      hi = 32'sh007f_ffff;
      lo = -32'sh0080_0000;
      if (v > hi) begin
         sffc_sat = hi[RW-1:0];
      end else if (v < lo) begin
         sffc_sat = lo[RW-1:0];
      end else begin
         sffc_sat = v[RW-1:0];
      end
   endfunction : sffc_sat

   // Clamp a written setting into its range
   function automatic logic [15:0] sffc_clamp(
      input logic [DW-1:0] w,
      input logic [15:0]   lo,
      input logic [15:0]   hi);
      if (w < {16'h0000, lo}) begin
         sffc_clamp = lo;
      end else if (w > {16'h0000, hi}) begin
         sffc_clamp = hi;
      end else begin
         sffc_clamp = w[15:0];
      end
   endfunction : sffc_clamp

   // ---------------------------------------------------------------
   // Registers
   // ---------------------------------------------------------------
   sffc_mode_t        mode_reg;
   logic              pctrl_reg;
   logic              pos_int_reg;
   logic              mfc_en_reg;
   logic              flim_reg;
   sffc_cfg_t         cfg_reg;     // Written by software
   sffc_cfg_t         act_reg;     // Taken over at each tick
   logic [3:0]        frc_src_reg; // Pending, restart-only
   logic [3:0]        spd_src_reg;
   logic [3:0]        frc_act_reg; // In force since restart
   logic [3:0]        spd_act_reg;
   logic [TCW-1:0]    tick_cnt_reg;
   logic              tick_reg;
   logic [2:0]        pls_sync_reg;
   logic [1:0]        sgn_sync_reg;
   logic signed [15:0] pls_cnt_reg;
   logic signed [15:0] pos_delta_reg;
   logic signed [31:0] int_ff_reg;
   logic signed [31:0] ext_spd_reg;
   logic signed [31:0] ext_frc_reg;

   logic               restart;
   logic               pos_mode;
   logic               spd_or_pos;
   logic               ext_allowed;
   logic               frc_ff_on;
   logic               spd_ff_on;
   logic               pls_rise;
   logic signed [31:0] int_raw;
   logic signed [31:0] spd_raw;
   logic signed [31:0] frc_raw;
   logic signed [31:0] spd_sum;
   logic signed [31:0] frc_sum;

   // ---------------------------------------------------------------
   // Register writes
   // ---------------------------------------------------------------
   assign restart = reg_wr && (reg_addr == A_CTRL)
                    && reg_wdata[C_RESTART];

   // Control and mode bits
   always_ff @(posedge core_clk) begin
      if (sys_rst) begin
         mode_reg    <= SFFC_MODE_SPEED;
         pctrl_reg   <= 1'b0;
         pos_int_reg <= 1'b0;
         mfc_en_reg  <= 1'b0;
         flim_reg    <= 1'b0;
      end else if (reg_wr && reg_addr == A_CTRL) begin
         mode_reg    <= sffc_mode_t'(reg_wdata[C_MODE_HI:C_MODE_LO]);
         pctrl_reg   <= reg_wdata[C_PCTRL];
         pos_int_reg <= reg_wdata[C_POS_INT];
         mfc_en_reg  <= reg_wdata[C_MFC_EN];
         flim_reg    <= reg_wdata[C_FLIM_ANA];
      end
   end

   // Tuning settings, clamped on write so out-of-range never lands, except ext_filt, which takes the low 16 bits unclamped
   always_ff @(posedge core_clk) begin
      if (sys_rst) begin
         cfg_reg.ff_gain  <= FF_GAIN_DEF;
         cfg_reg.ff_filt  <= FILT_DEF;
         cfg_reg.frc_gain <= FRC_GAIN_DEF;
         cfg_reg.ext_filt <= FILT_DEF;
         cfg_reg.spd_gain <= SPD_GAIN_DEF;
         cfg_reg.mf_comb  <= 1'b0;
      end else if (reg_wr) begin
         case (reg_addr)
            A_CTRL:     cfg_reg.mf_comb <= reg_wdata[C_MF_COMB];
            A_FF_GAIN:  cfg_reg.ff_gain <=
               sffc_clamp(reg_wdata, FF_GAIN_DEF, FF_GAIN_MAX);
            A_FF_FILT:  cfg_reg.ff_filt <=
               sffc_clamp(reg_wdata, FILT_DEF, FF_FILT_MAX);
            A_FRC_GAIN: cfg_reg.frc_gain <=
               sffc_clamp(reg_wdata, FRC_GAIN_MIN, FRC_GAIN_MAX);
            A_EXT_FILT: cfg_reg.ext_filt <= reg_wdata[15:0];
            A_SPD_GAIN: cfg_reg.spd_gain <=
               sffc_clamp(reg_wdata, SPD_GAIN_MIN, SPD_GAIN_MAX);
            default:    cfg_reg <= cfg_reg;
         endcase
      end
   end

   // Source selects: pending until a restart, then in force
   always_ff @(posedge core_clk) begin
      if (sys_rst) begin
         frc_src_reg <= SRC_OFF;
         spd_src_reg <= SRC_OFF;
      end else if (reg_wr && reg_addr == A_SRC_SEL) begin
         frc_src_reg <= reg_wdata[S_FRC_HI:S_FRC_LO];
         spd_src_reg <= reg_wdata[S_SPD_HI:S_SPD_LO];
      end
   end

   always_ff @(posedge core_clk) begin
      if (sys_rst) begin
         frc_act_reg <= SRC_OFF;
         spd_act_reg <= SRC_OFF;
      end else if (restart) begin
         frc_act_reg <= frc_src_reg;
         spd_act_reg <= spd_src_reg;
      end
   end

   // ---------------------------------------------------------------
   // Loop update tick
   // ---------------------------------------------------------------
   always_ff @(posedge core_clk) begin
      if (sys_rst) begin
         tick_cnt_reg <= '0;
         tick_reg     <= 1'b0;
      end else if (tick_cnt_reg == TCW'(TICK_CYC - 1)) begin
         tick_cnt_reg <= '0;
         tick_reg     <= 1'b1;
      end else begin
         tick_cnt_reg <= tick_cnt_reg + 1'b1;
         tick_reg     <= 1'b0;
      end
   end

   // Settings change only on the tick so a step never lands mid-update
   always_ff @(posedge core_clk) begin
      if (sys_rst) begin
         act_reg <= '{FF_GAIN_DEF, FILT_DEF, FRC_GAIN_DEF,
                      FILT_DEF, SPD_GAIN_DEF, 1'b0};
      end else if (tick_reg) begin
         act_reg <= cfg_reg;
      end
   end

   // ---------------------------------------------------------------
   // Position reference pulse counting
   // ---------------------------------------------------------------
   always_ff @(posedge core_clk) begin
      if (sys_rst) begin
         pls_sync_reg <= '0;
         sgn_sync_reg <= '0;
      end else begin
         pls_sync_reg <= {pls_sync_reg[1:0], ref_pulse_in};
         sgn_sync_reg <= {sgn_sync_reg[0], ref_sign_in};
      end
   end

   // Only the second and third stages are inspected
   assign pls_rise = pls_sync_reg[1] && !pls_sync_reg[2];

   // Pulses per tick; an edge on the tick cycle starts the next count
   always_ff @(posedge core_clk) begin
      if (sys_rst) begin
         pls_cnt_reg   <= '0;
         pos_delta_reg <= '0;
      end else if (tick_reg) begin
         pos_delta_reg <= pls_cnt_reg;
         pls_cnt_reg   <= !pls_rise ? 16'sh0000 :
                          (sgn_sync_reg[1] ? -16'sh0001 : 16'sh0001);
      end else if (pls_rise) begin
         pls_cnt_reg <= sgn_sync_reg[1] ? pls_cnt_reg - 16'sh0001
                                        : pls_cnt_reg + 16'sh0001;
      end
   end

   // ---------------------------------------------------------------
   // Feedforward selection
   // ---------------------------------------------------------------
   assign pos_mode    = (mode_reg == SFFC_MODE_POS);
   assign spd_or_pos  = pos_mode || (mode_reg == SFFC_MODE_SPEED);
   // Model following blocks external inputs unless combined
   assign ext_allowed = !mfc_en_reg || act_reg.mf_comb;
   assign frc_ff_on   = spd_or_pos && ext_allowed
                        && (frc_act_reg == FRC_SRC_ON);
   assign spd_ff_on   = pos_mode && ext_allowed
                        && (spd_act_reg == SPD_SRC_ON);

   // Analog force limit yields to force feedforward on the shared input
   assign force_limit_on  = flim_reg && !frc_ff_on;
   assign p_control_on    = pctrl_reg && spd_or_pos;
   assign pos_integral_on = pos_int_reg && pos_mode;
   assign loop_tick       = tick_reg;

   // ---------------------------------------------------------------
   // Scaling
   // ---------------------------------------------------------------
   // Internal term: pulses per tick times percent gain
   assign int_raw = pos_mode ? (32'(pos_delta_reg)
                    * $signed({16'h0000, act_reg.ff_gain}))
                    / PCT_FULL : 32'sh0;
   // Volts over gain volts-per-rated, in rated counts
   assign spd_raw = spd_ff_on ? (32'(speed_adc_mv) * RATED)
                    / ($signed({16'h0000, act_reg.spd_gain})
                    * MV_CENTI) : 32'sh0;
   assign frc_raw = frc_ff_on ? (32'(force_adc_mv) * RATED)
                    / ($signed({16'h0000, act_reg.frc_gain})
                    * MV_DECI) : 32'sh0;

   // ---------------------------------------------------------------
   // Filters, one step per tick
   // ---------------------------------------------------------------
   always_ff @(posedge core_clk) begin
      if (sys_rst) begin
         int_ff_reg <= '0;
      end else if (tick_reg) begin
         int_ff_reg <= sffc_lag(int_ff_reg, int_raw,
                                act_reg.ff_filt);
      end
   end

   always_ff @(posedge core_clk) begin
      if (sys_rst) begin
         ext_spd_reg <= '0;
         ext_frc_reg <= '0;
      end else if (tick_reg) begin
         ext_spd_reg <= sffc_lag(ext_spd_reg, spd_raw,
                                 act_reg.ext_filt);
         ext_frc_reg <= sffc_lag(ext_frc_reg, frc_raw,
                                 act_reg.ext_filt);
      end
   end

   // ---------------------------------------------------------------
   // Summing and outputs
   // ---------------------------------------------------------------
   // Gated here too: stale filter state must not leak across modes
   assign spd_sum = 32'(speed_ref_in) + (pos_mode ? int_ff_reg : 32'sh0)
                    + (spd_ff_on ? ext_spd_reg : 32'sh0);
   assign frc_sum = 32'(force_ref_in)
                    + (frc_ff_on ? ext_frc_reg : 32'sh0);

   // Summed references leave on the tick, clipped
   always_ff @(posedge core_clk) begin
      if (sys_rst) begin
         speed_ref_out <= '0;
         force_ref_out <= '0;
      end else if (tick_reg) begin
         speed_ref_out <= sffc_sat(spd_sum);
         force_ref_out <= sffc_sat(frc_sum);
      end
   end

   // ---------------------------------------------------------------
   // Register reads, data one cycle after the strobe
   // ---------------------------------------------------------------
   always_ff @(posedge core_clk) begin
      if (sys_rst) begin
         reg_rdata <= '0;
      end else if (reg_rd) begin
         case (reg_addr)
            A_CTRL:     reg_rdata <= {26'h0, cfg_reg.mf_comb, mfc_en_reg,
                                      pos_int_reg, pctrl_reg, mode_reg}
                                     | {25'h0, flim_reg, 6'h00};
            A_FF_GAIN:  reg_rdata <= {16'h0, cfg_reg.ff_gain};
            A_FF_FILT:  reg_rdata <= {16'h0, cfg_reg.ff_filt};
            A_FRC_GAIN: reg_rdata <= {16'h0, cfg_reg.frc_gain};
            A_EXT_FILT: reg_rdata <= {16'h0, cfg_reg.ext_filt};
            A_SPD_GAIN: reg_rdata <= {16'h0, cfg_reg.spd_gain};
            A_SRC_SEL:  reg_rdata <= {24'h0, spd_src_reg, frc_src_reg};
            A_STATUS:   reg_rdata <= {16'h0, spd_act_reg, frc_act_reg,
                                      3'h0, force_limit_on, spd_ff_on,
                                      frc_ff_on, pos_integral_on,
                                      p_control_on};
            A_SPD_FF:   reg_rdata <= ext_spd_reg;
            A_FRC_FF:   reg_rdata <= ext_frc_reg;
            default:    reg_rdata <= '0;
         endcase
      end
   end
endmodule : sffc_top

/* tb/sffc_host.sv */
// Host controller model: pulse train and analog references
`timescale 1ns/100ps
module sffc_host (
   input  wire logic               core_clk,
   input  wire logic               run,
   input  wire logic               dir,
   input  wire logic signed [15:0] spd_mv,
   input  wire logic signed [15:0] frc_mv,
   output logic                    ref_pulse_in = 1'b0,
   output logic                    ref_sign_in = 1'b0,
   output logic signed [15:0]      speed_adc_mv = 16'sh0000,
   output logic signed [15:0]      force_adc_mv = 16'sh0000
);
   logic [2:0] ph_reg = 3'h0;
   // One pulse each 8 cycles, so a loop window with run held throughout holds 250 of them
   always @(posedge core_clk) begin
      ph_reg       <= run ? ph_reg + 3'h1 : 3'h0;
      ref_pulse_in <= run & ph_reg[2];
      ref_sign_in  <= dir;
   end
   // Speed and force levels are registered on the same edge, each from its own input
   always @(posedge core_clk) begin
      speed_adc_mv <= spd_mv;
      force_adc_mv <= frc_mv;
   end
endmodule : sffc_host

/* tb/sffc_chk.sv */
// Port checker for the servo feedforward stage
`timescale 1ns/100ps
module sffc_chk
   import sffc_pkg::*;
(
   input wire logic                 core_clk,
   input wire logic                 sys_rst,
   input wire logic [AW-1:0]        reg_addr,
   input wire logic [DW-1:0]        reg_wdata,
   input wire logic                 reg_wr,
   input wire logic                 reg_rd,
   input wire logic [DW-1:0]        reg_rdata,
   input wire logic signed [RW-1:0] speed_ref_in,
   input wire logic signed [RW-1:0] force_ref_in,
   input wire logic signed [RW-1:0] speed_ref_out,
   input wire logic signed [RW-1:0] force_ref_out,
   input wire logic                 loop_tick,
   input wire logic                 p_control_on,
   input wire logic                 pos_integral_on
);
   default clocking @(posedge core_clk); endclocking
   default disable iff (sys_rst);
   logic [3:0]  ctl_reg;
   logic [10:0] gap_reg;
   // Mirror of mode, P request and integral enable, seen from host writes
   always_ff @(posedge core_clk) begin
      if (sys_rst) ctl_reg <= 4'h0;
      else if (reg_wr && reg_addr == A_CTRL) ctl_reg <= reg_wdata[3:0];
   end
   // Cycles since the last tick; a stuck tick shows as a runaway count
   always_ff @(posedge core_clk) begin
      if (sys_rst || loop_tick) gap_reg <= 11'h000;
      else gap_reg <= gap_reg + 11'h001;
   end
   // ---------------------------------------------------------------
   // Assertions
   // ---------------------------------------------------------------
   chk_rdata_hold: assert property (
      !$past(reg_rd) |-> $stable(reg_rdata))
      else $error("read data moved without a read");
   chk_unmapped_zero: assert property (
      reg_rd && reg_addr > A_FRC_FF |=> reg_rdata == 32'h0000_0000)
      else $error("unmapped read not zero");
   chk_spd_at_tick: assert property (
      $changed(speed_ref_out) |-> loop_tick || $past(loop_tick))
      else $error("speed output moved between ticks");
   chk_frc_at_tick: assert property (
      $changed(force_ref_out) |-> loop_tick || $past(loop_tick))
      else $error("force output moved between ticks");
   chk_tick_period: assert property (
      loop_tick |-> gap_reg >= 11'd1998 && gap_reg <= 11'd2000)
      else $error("loop tick spacing wrong");
   chk_tick_due: assert property (gap_reg <= 11'd2000)
      else $error("loop tick missing");
   chk_pctl_mode: assert property (
      p_control_on == (ctl_reg[2] && !ctl_reg[1]))
      else $error("proportional select in wrong mode");
   chk_pint_mode: assert property (
      pos_integral_on == (ctl_reg[3] && ctl_reg[1:0] == 2'b01))
      else $error("position integral in wrong mode");
   chk_spd_no_ff: assert property (
      loop_tick && ctl_reg[1:0] != 2'b01 && $stable(speed_ref_in)
      |=> speed_ref_out == $past(speed_ref_in))
      else $error("speed feedforward outside position mode");
   chk_frc_no_ff: assert property (
      loop_tick && ctl_reg[1] && $stable(force_ref_in)
      |=> force_ref_out == $past(force_ref_in))
      else $error("force feedforward in force or other mode");
   cov_pctl: cover property (p_control_on);
   cov_pint: cover property (pos_integral_on);
   cov_spd_move: cover property (loop_tick ##1 $changed(speed_ref_out));
endmodule : sffc_chk
bind sffc_top sffc_chk sffc_chk_inst (.core_clk, .sys_rst, .reg_addr,
   .reg_wdata, .reg_wr, .reg_rd, .reg_rdata, .speed_ref_in, .force_ref_in,
   .speed_ref_out, .force_ref_out, .loop_tick, .p_control_on,
   .pos_integral_on);

/* tb/tb.sv */
// Self-checking testbench of the servo feedforward stage
`timescale 1ns/100ps
module tb;
   import sffc_pkg::*;
   logic                 core_clk = 1'b0;
   logic                 sys_rst = 1'b1;
   logic [AW-1:0]        reg_addr = 8'h00;
   logic [DW-1:0]        reg_wdata = 32'h0, reg_rdata;
   logic                 reg_wr = 1'b0, reg_rd = 1'b0;
   logic                 run = 1'b0, dir = 1'b0, ref_pulse_in, ref_sign_in;
   logic signed [15:0]   spd_mv = 16'sh0, frc_mv = 16'sh0;
   logic signed [15:0]   speed_adc_mv, force_adc_mv;
   logic signed [RW-1:0] speed_ref_in = 24'sh0, force_ref_in = 24'sh0;
   logic signed [RW-1:0] speed_ref_out, force_ref_out;
   logic                 loop_tick, p_control_on, pos_integral_on;
   logic                 force_limit_on;
   logic [AW-1:0]        da [9] = '{A_FF_GAIN, A_FF_FILT, A_FRC_GAIN,
      A_EXT_FILT, A_SPD_GAIN, A_CTRL, A_SRC_SEL, A_STATUS, 8'h28};
   logic [DW-1:0]        dv [9] = '{0, 0, 32'h1e, 0, 32'h258, 0, 0, 0, 0};
   logic [AW-1:0]        ca [7] = '{A_FF_GAIN, A_FF_FILT, A_FRC_GAIN,
      A_FRC_GAIN, A_EXT_FILT, A_SPD_GAIN, A_SPD_GAIN};
   logic [DW-1:0]        cw [7] = '{200, 32'hffff, 5, 200, 32'hffff, 100,
      4000};
   logic [DW-1:0]        cr [7] = '{FF_GAIN_MAX, FF_FILT_MAX, FRC_GAIN_MIN,
      FRC_GAIN_MAX, 32'hffff, SPD_GAIN_MIN, SPD_GAIN_MAX};
   int                   failures = 0, cmp_count = 0;
   // 200 MHz core clock
   always #2.5 core_clk = ~core_clk;
   sffc_top sffc_top_inst (.core_clk, .sys_rst, .reg_addr, .reg_wdata,
      .reg_wr, .reg_rd, .reg_rdata, .ref_pulse_in, .ref_sign_in,
      .speed_adc_mv, .force_adc_mv, .speed_ref_in, .force_ref_in,
      .speed_ref_out, .force_ref_out, .loop_tick, .p_control_on,
      .pos_integral_on, .force_limit_on);
   sffc_host sffc_host_inst (.core_clk, .run, .dir, .spd_mv, .frc_mv,
      .ref_pulse_in, .ref_sign_in, .speed_adc_mv, .force_adc_mv);
   // ---------------------------------------------------------------
   // Bus and compare tasks
   // ---------------------------------------------------------------
   task automatic chk_word(input logic [DW-1:0] got, input logic [DW-1:0] e);
      cmp_count++;
      if (got !== e) begin
         failures++;
         $display("wrong value at %0t: got %h expected %h", $time, got, e);
      end
   endtask : chk_word
   task automatic chk_ref(input logic [RW-1:0] got, input logic [RW-1:0] e);
      chk_word({{8{got[RW-1]}}, got}, {{8{e[RW-1]}}, e});
   endtask : chk_ref
   // Strobe lasts one cycle and one idle cycle follows, so calls never collide
   task automatic wr(input logic [AW-1:0] a, input logic [DW-1:0] d);
      reg_addr  <= a;
      reg_wdata <= d;
      reg_wr    <= 1'b1;
      @(posedge core_clk);
      reg_wr    <= 1'b0;
      @(posedge core_clk);
   endtask : wr
   task automatic rd(input logic [AW-1:0] a, input logic [DW-1:0] e);
      reg_addr <= a;
      reg_rd   <= 1'b1;
      @(posedge core_clk);
      reg_rd   <= 1'b0;
      #1 chk_word(reg_rdata, e);
      @(posedge core_clk);
   endtask : rd
   // Waits n ticks, at least two: one to load the filters, one to reach the outputs
   task automatic chk_out(input int n, input int es, input int ef);
      repeat (n) @(posedge loop_tick);
      repeat (4) @(posedge core_clk);
      chk_ref(speed_ref_out, es[RW-1:0]);
      chk_ref(force_ref_out, ef[RW-1:0]);
   endtask : chk_out
   task automatic print_verdict;
      $display("comparisons %0d mismatches %0d", cmp_count, failures);
      if (failures == 0 && cmp_count > 0)
         $display("Run complete: PASS");
      else
         $display("Run complete: FAIL");
      $finish;
   endtask : print_verdict
   // Watchdog well beyond the expected 62k cycles
   initial begin
      repeat (90000) @(posedge core_clk);
      failures++;
      print_verdict();
   end
   // ---------------------------------------------------------------
   // Test sequence
   // ---------------------------------------------------------------
   initial begin
      repeat (8) @(posedge core_clk);
      sys_rst <= 1'b0;
      @(posedge core_clk);
      foreach (da[i]) rd(da[i], dv[i]);
      $display("test done: reset values");
      foreach (ca[i]) begin
         wr(ca[i], cw[i]);
         rd(ca[i], cr[i]);
      end
      for (int i = 0; i < 5; i++) wr(da[i], dv[i]);
      $display("test done: setting ranges");
      wr(A_SRC_SEL, 32'h12);
      rd(A_STATUS, 32'h0);
      wr(A_CTRL, 32'h81);
      rd(A_STATUS, 32'h120c);
      spd_mv <= 16'sd600;
      frc_mv <= 16'sd300;
      speed_ref_in <= 24'sd1000;
      force_ref_in <= -24'sd1000;
      chk_out(2, 1409, -591);
      rd(A_SPD_FF, 32'd409);
      rd(A_FRC_FF, 32'd409);
      $display("test done: external feedforward");
      for (int m = 0; m < 4; m++) begin
         wr(A_CTRL, m);
         chk_out(2, m == 1 ? 1409 : 1000, m < 2 ? -591 : -1000);
      end
      wr(A_CTRL, 32'h11);
      chk_out(2, 1000, -1000);
      wr(A_CTRL, 32'h31);
      chk_out(3, 1409, -591);
      $display("test done: mode gating");
      wr(A_CTRL, 32'h0d);
      chk_word({p_control_on, pos_integral_on}, 32'h3);
      wr(A_CTRL, 32'h0e);
      chk_word({p_control_on, pos_integral_on}, 32'h0);
      wr(A_CTRL, 32'h41);
      chk_word(force_limit_on, 32'h0);
      wr(A_SRC_SEL, 32'h10);
      wr(A_CTRL, 32'hc1);
      chk_word(force_limit_on, 32'h1);
      chk_out(2, 1409, -1000);
      $display("test done: exclusive functions");
      speed_ref_in <= 24'sh7ffff0;
      chk_out(2, 8388607, -1000);
      spd_mv <= -16'sd600;
      speed_ref_in <= -24'sh7ffff0;
      chk_out(2, -8388608, -1000);
      wr(A_EXT_FILT, 32'h1);
      @(posedge loop_tick);
      spd_mv <= 16'sd0;
      @(posedge loop_tick);
      repeat (4) @(posedge core_clk);
      rd(A_SPD_FF, 32'hffff_ff33);
      $display("test done: saturation and filter");
      speed_ref_in <= 24'sd0;
      wr(A_EXT_FILT, 32'h0);
      wr(A_FF_GAIN, 32'd80);
      run <= 1'b1;
      chk_out(4, 200, -1000);
      wr(A_FF_GAIN, 32'd50);
      dir <= 1'b1;
      chk_out(4, -125, -1000);
      $display("test done: internal feedforward");
      print_verdict();
   end
endmodule : tb
